/* File: src/eeprom_access_cfg.svh */
/*
 * Offsets, bit positions and timing figures of the eeprom access block.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef EEPROM_ACCESS_CFG_SVH
`define EEPROM_ACCESS_CFG_SVH

// i/o register offsets (6-bit i/o space)
`define EE_OFS_CTRL       6'h1D
`define EE_OFS_DATA       6'h20
`define EE_OFS_ADDR_LO    6'h21
`define EE_OFS_ADDR_HI    6'h22

// control register bit positions
`define EE_BIT_RDY_EN     3
`define EE_BIT_ARM        2
`define EE_BIT_WSTROBE    1
`define EE_BIT_RSTROBE    0

// address width of the largest variant, and of the built variant
`define EE_ADDR_MAX_W     11
`define EE_ADDR_W_DEFAULT 11

// cycle figures in cpu clocks
`define EE_ARM_CYCLES     4
`define EE_READ_STALL     4
`define EE_WRITE_STALL    2

// clock and calibrated oscillator periods, in ns
`define EE_CLK_PERIOD_NS  10
`define EE_OSC_PERIOD_NS  125
// oscillator tick divider, rounded down to whole cpu cycles
`define EE_OSC_DIV        (`EE_OSC_PERIOD_NS / `EE_CLK_PERIOD_NS)

// write duration in oscillator cycles
`define EE_WRITE_OSC_CYCLES 27072

`endif

/* File: src/eeprom_access_pkg.sv */
/*
 * Types shared by the eeprom access controller and its write timer.
 * Assumes eeprom_access_cfg.svh is on the include path.
 */
`include "eeprom_access_cfg.svh"

package eeprom_access_pkg;

	typedef logic [`EE_ADDR_MAX_W-1:0] ee_addr_t;

	// processor i/o register access
	typedef struct packed {
		logic [5:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} io_req_s;

	typedef struct packed {
		logic        busy;
		logic [3:0]  div;
		logic [14:0] cnt;
	} timer_state_s;

	typedef struct packed {
		ee_addr_t   addr;
		logic [7:0] data;
		logic       rdy_en;
		logic       arm;
		logic [2:0] arm_cnt;
		logic [2:0] stall_cnt;
		logic [7:0] rdata;
		ee_addr_t   wr_addr;
		logic [7:0] wr_data;
	} ctrl_state_s;

endpackage

/* File: src/write_timer.sv */
/*
 * Self-timed write duration: divides the cpu clock down to the
 * calibrated oscillator rate and counts the write length in ticks.
 * Assumes its reset is the power-on reset only, so that a system
 * reset never cuts a running write short.
 */
`timescale 1ns/1ps

`include "eeprom_access_cfg.svh"

module write_timer #(
	parameter int unsigned OSC_CYCLES = `EE_WRITE_OSC_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	import eeprom_access_pkg::*;

	localparam logic [3:0]  DIV_LAST = 4'(`EE_OSC_DIV - 1);
	localparam logic [14:0] CNT_LAST = 15'(OSC_CYCLES - 1);

	timer_state_s st_r;
	timer_state_s st_nxt;
	logic         tick;

	assign tick   = (st_r.div == DIV_LAST);
	assign done_o = st_r.busy && tick && (st_r.cnt == CNT_LAST);
	assign busy_o = st_r.busy;

	always_comb begin
		st_nxt = st_r;
		if (!st_r.busy) begin
			if (start_i) begin
				st_nxt.busy = 1'b1;
				st_nxt.div  = 4'h0;
				st_nxt.cnt  = 15'h0000;
			end
		end else if (done_o) begin
			st_nxt.busy = 1'b0;
		end else if (tick) begin
			st_nxt.div = 4'h0;
			st_nxt.cnt = st_r.cnt + 15'h0001;
		end else begin
			st_nxt.div = st_r.div + 4'h1;
		end
		if (!rst_n_i) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_r <= st_nxt;
	end

endmodule

/* File: src/eeprom_access_controller.sv */
/*
 * CPU-side eeprom access controller: address, data and control
 * registers on the processor i/o bus, armed write sequence, self-timed
 * write, read with cpu stall, ready interrupt and byte array.
 * Assumes a single-cycle i/o bus from the core on clk_i, a power-on
 * reset por_n_i and a system reset rst_n_i, both synchronous.
 */
`timescale 1ns/1ps

`include "eeprom_access_cfg.svh"

module eeprom_access_controller #(
	parameter int unsigned ADDR_W     = `EE_ADDR_W_DEFAULT,
	parameter int unsigned OSC_CYCLES = `EE_WRITE_OSC_CYCLES
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       por_n_i,
	input  wire eeprom_access_pkg::io_req_s io_req_i,
	input  wire logic                       global_irq_en_i,
	input  wire logic                       sleep_pd_i,
	output logic [7:0]                      io_rdata_o,
	output logic                            cpu_stall_o,
	output logic                            ready_irq_o,
	output logic                            clk_keep_o
);
	import eeprom_access_pkg::*;

	localparam ee_addr_t ADDR_MASK = ee_addr_t'((1 << ADDR_W) - 1);
	localparam int       DEPTH     = 1 << `EE_ADDR_MAX_W;

	ctrl_state_s st_r;
	ctrl_state_s st_nxt;
	logic [7:0]  mem [DEPTH];
	logic        busy;
	logic        done;
	logic        wr_ctrl;
	logic        start;
	logic        rd_go;
	logic [7:0]  rd_mux;

	write_timer #(
		.OSC_CYCLES(OSC_CYCLES)
	) u_timer (
		.clk_i  (clk_i),
		.rst_n_i(por_n_i),
		.start_i(start),
		.busy_o (busy),
		.done_o (done)
	);

	assign wr_ctrl = io_req_i.wr && (io_req_i.addr == `EE_OFS_CTRL);
	assign start = wr_ctrl && io_req_i.wdata[`EE_BIT_WSTROBE] && st_r.arm
		&& !busy && !cpu_stall_o && rst_n_i;
	assign rd_go = wr_ctrl && io_req_i.wdata[`EE_BIT_RSTROBE] && !busy;

	// cpu halted while the stall count runs
	assign cpu_stall_o = (st_r.stall_cnt != 3'h0);
	// level interrupt while no write is in progress
	assign ready_irq_o = st_r.rdy_en && global_irq_en_i && !busy;
	// clock held for the write, regardless of sleep request
	assign clk_keep_o = busy;

	always_comb begin
		rd_mux = 8'h00;
		unique case (io_req_i.addr)
			`EE_OFS_CTRL: begin
				// high nibble zero, strobe mirrors busy
				rd_mux = {4'h0, st_r.rdy_en, st_r.arm, busy, 1'b0};
			end
			`EE_OFS_DATA: begin
				rd_mux = st_r.data;
			end
			`EE_OFS_ADDR_LO: begin
				rd_mux = st_r.addr[7:0];
			end
			`EE_OFS_ADDR_HI: begin
				// bits above the variant width read zero
				rd_mux = {5'h00, st_r.addr[`EE_ADDR_MAX_W-1:8]};
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		if (io_req_i.rd) begin
			st_nxt.rdata = rd_mux;
		end
		if (cpu_stall_o) begin
			st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
		end
		// arm times out after four cycles
		if (st_r.arm) begin
			if (st_r.arm_cnt == 3'h1) begin
				st_nxt.arm = 1'b0;
			end
			st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
		end
		if (io_req_i.wr) begin
			unique case (io_req_i.addr)
				`EE_OFS_DATA: begin
					st_nxt.data = io_req_i.wdata;
				end
				`EE_OFS_ADDR_LO: begin
					if (!busy) begin
						st_nxt.addr[7:0] = io_req_i.wdata & ADDR_MASK[7:0];
					end
				end
				`EE_OFS_ADDR_HI: begin
					if (!busy) begin
						st_nxt.addr[`EE_ADDR_MAX_W-1:8] =
							io_req_i.wdata[2:0] & ADDR_MASK[10:8];
					end
				end
				`EE_OFS_CTRL: begin
					st_nxt.rdy_en = io_req_i.wdata[`EE_BIT_RDY_EN];
					if (io_req_i.wdata[`EE_BIT_ARM]) begin
						st_nxt.arm     = 1'b1;
						st_nxt.arm_cnt = 3'(`EE_ARM_CYCLES);
					end
				end
				default: begin
				end
			endcase
		end
		// latch current address and data at start
		if (start) begin
			st_nxt.wr_addr   = st_r.addr;
			st_nxt.wr_data   = st_r.data;
			st_nxt.arm       = 1'b0;
			st_nxt.stall_cnt = 3'(`EE_WRITE_STALL);
		end
		// byte fetched into data register in one step
		if (rd_go) begin
			st_nxt.data      = mem[st_r.addr];
			st_nxt.stall_cnt = 3'(`EE_READ_STALL);
		end
		// system reset spares the pending write target
		if (!rst_n_i) begin
			st_nxt         = '0;
			st_nxt.wr_addr = st_r.wr_addr;
			st_nxt.wr_data = st_r.wr_data;
			st_nxt.addr    = st_r.addr;
		end
		if (!por_n_i) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_r <= st_nxt;
	end

	// commit when the timed duration ends
	always_ff @(posedge clk_i) begin
		if (done) begin
			mem[st_r.wr_addr] <= st_r.wr_data;
		end
	end

	assign io_rdata_o = st_r.rdata;

	// assertion helpers
	int unsigned busy_len;
	always_ff @(posedge clk_i) begin
		if (!por_n_i || !busy) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy_len + 1;
		end
	end
	localparam int unsigned WR_CYC = OSC_CYCLES * `EE_OSC_DIV;

	// a strobe inside the window ends the arm early; only timeouts here
	a_arm_timeout: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		$rose(st_r.arm) ##0 (rst_n_i && !start) [*4]
		|-> st_r.arm ##1 !st_r.arm)
		else $error("arm bit not cleared after four cycles");
	a_no_unarmed_wr: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		!busy && !st_r.arm |=> !busy)
		else $error("write began without arm");
	a_armed_start: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		start |=> busy && st_r.wr_addr == $past(st_r.addr))
		else $error("armed strobe did not start write");
	a_write_stall: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		start && rst_n_i |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
		else $error("write stall not two cycles");
	a_read_stall: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		rd_go && rst_n_i |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
		else $error("read stall not four cycles");
	a_read_data: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		rd_go && rst_n_i |=> st_r.data == mem[$past(st_r.addr)])
		else $error("read data not loaded");
	a_addr_frozen: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		busy && $past(busy) && rst_n_i |-> $stable(st_r.addr))
		else $error("address changed during write");
	a_write_length: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		done |-> busy_len == WR_CYC - 1)
		else $error("write duration wrong");
	a_reset_keeps: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		busy && !rst_n_i && !done |=> busy)
		else $error("reset aborted write");
	a_strobe_clear: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		done |=> !busy ##0 (st_r.rdy_en && global_irq_en_i) == ready_irq_o)
		else $error("strobe not cleared at write end");
	a_irq_level: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		busy |-> !ready_irq_o)
		else $error("ready interrupt during write");
	a_sleep_clock: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		sleep_pd_i && busy |-> clk_keep_o)
		else $error("clock dropped during write");
	a_high_zero: assert property (
		@(posedge clk_i) disable iff (!por_n_i)
		(st_r.addr & ~ADDR_MASK) == '0)
		else $error("address bits beyond width set");

	c_write: cover property (@(posedge clk_i) start ##[1:300] busy);
	c_done: cover property (@(posedge clk_i) done);
	c_read: cover property (@(posedge clk_i) rd_go);
	c_timeout: cover property (@(posedge clk_i) $fell(st_r.arm) && !busy);

endmodule

/* File: bench/cpu_model.sv */
/*
 * Processor core model on the eeprom i/o bus: single-cycle accesses.
 * Assumes the controller's clock and its stall output.
 */
`timescale 1ns/1ps

module cpu_model (
	input  wire logic                  clk_i,
	input  wire logic [7:0]            io_rdata_i,
	input  wire logic                  cpu_stall_i,
	output eeprom_access_pkg::io_req_s io_req_o
);
	import eeprom_access_pkg::*;

	int         stalls;
	logic [7:0] en = 8'h00;

	initial io_req_o = '0;

	// no access while the core is halted
	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		while (cpu_stall_i === 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		io_req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk_i);
		#1;
		io_req_o.wr = 1'b0;
		stalls = 0;
		while (cpu_stall_i === 1'b1 && stalls < 20) begin
			stalls++;
			@(posedge clk_i);
			#1;
		end
		// idle edge before the next access
		@(posedge clk_i);
		#1;
	endtask

	task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
		while (cpu_stall_i === 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		io_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk_i);
		#1;
		io_req_o.rd = 1'b0;
		d = io_rdata_i;
		// idle edge before the next access
		@(posedge clk_i);
		#1;
	endtask

	task automatic wait_idle();
		logic [7:0] c;
		int         n;
		n = 0;
		c = 8'hFF;
		while (c[1] !== 1'b0 && n < 100) begin
			io_rd(6'h1D, c);
			n++;
		end
	endtask

	task automatic ee_write(input logic [10:0] a, input logic [7:0] d);
		wait_idle();
		io_wr(6'h22, {5'h00, a[10:8]});
		io_wr(6'h21, a[7:0]);
		io_wr(6'h20, d);
		io_wr(6'h1D, en | 8'h04);
		io_wr(6'h1D, en | 8'h06);
	endtask
endmodule

/* File: bench/tb_top.sv */
/*
 * Self-checking bench for the eeprom access controller.
 * Assumes cpu_model as the core and a shortened write duration.
 */
`timescale 1ns/1ps

module tb_top;
	import eeprom_access_pkg::*;

	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       por_n_i = 1'b0;
	logic       global_irq_en = 1'b0;
	logic       sleep = 1'b0;
	io_req_s    req;
	logic [7:0] rdata;
	logic       stall;
	logic       irq;
	logic       keep;
	logic [7:0] v;
	int         miscompares = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         t0;

	always #5 clk_i = ~clk_i;

	eeprom_access_controller #(.ADDR_W(11), .OSC_CYCLES(5)) dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
		.io_req_i(req), .global_irq_en_i(global_irq_en),
		.sleep_pd_i(sleep), .io_rdata_o(rdata), .cpu_stall_o(stall),
		.ready_irq_o(irq), .clk_keep_o(keep));

	cpu_model cpu_u (.clk_i(clk_i), .io_rdata_i(rdata),
		.cpu_stall_i(stall), .io_req_o(req));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] g, e, input string m);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic t_regs();
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h00, "control after reset");
		cpu_u.io_rd(6'h3F, v);
		chk(v, 8'h00, "unmapped read");
		cpu_u.io_wr(6'h22, 8'hFF);
		cpu_u.io_rd(6'h22, v);
		chk(v, 8'h07, "address high mask");
		$display("t_regs done");
	endtask

	task automatic t_arm();
		cpu_u.io_wr(6'h1D, 8'h02);
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h00, "strobe without arm");
		cpu_u.io_wr(6'h1D, 8'h04);
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h04, "arm set");
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h04, "arm held fourth cycle");
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h00, "arm cleared after four");
		cpu_u.io_wr(6'h1D, 8'h02);
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h00, "late strobe");
		$display("t_arm done");
	endtask

	task automatic t_write();
		cpu_u.en = 8'h08;
		global_irq_en = 1'b1;
		cpu_u.ee_write(11'h5A5, 8'hC3);
		t0 = cyc;
		chk(8'(cpu_u.stalls), 8'h02, "write stall");
		chk({7'h00, irq}, 8'h00, "irq while busy");
		sleep = 1'b1;
		cpu_u.io_wr(6'h21, 8'h00);
		cpu_u.io_wr(6'h1D, 8'h09);
		cpu_u.io_rd(6'h1D, v);
		chk(v, 8'h0A, "busy status");
		chk({7'h00, keep}, 8'h01, "clock kept");
		rst_n_i = 1'b0;
		@(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		cpu_u.wait_idle();
		v = 8'((cyc - t0) > 52 && (cyc - t0) < 66);
		chk(v, 8'h01, "write length");
		chk({7'h00, keep}, 8'h00, "clock released");
		sleep = 1'b0;
		cpu_u.io_rd(6'h21, v);
		chk(v, 8'hA5, "address frozen");
		cpu_u.io_wr(6'h20, 8'h00);
		cpu_u.io_wr(6'h1D, 8'h09);
		chk(8'(cpu_u.stalls), 8'h04, "read stall");
		chk({7'h00, irq}, 8'h01, "ready irq");
		cpu_u.io_rd(6'h20, v);
		chk(v, 8'hC3, "read back");
		global_irq_en = 1'b0;
		#1;
		chk({7'h00, irq}, 8'h00, "irq masked");
		$display("t_write done");
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		#1;
		por_n_i = 1'b1;
		rst_n_i = 1'b1;
		t_regs();
		t_arm();
		t_write();
		end_of_test();
	end
endmodule
